// [cnsc_can_model.sv]
// Purpose: CAN controller stand-in that takes the captured node setup
// Assumes: cfg_in only means something once cfg_valid is high
// Notes:   Loads cfg_in on every cycle cfg_valid is high; the captured setup then holds, as the real controller joins the bus once
`timescale 1ns/1ns
module cnsc_can_model
	import cnsc_pkg::*;
(
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire cnsc_cfg_s cfg_in,
	input  wire logic      cfg_valid,
	output cnsc_cfg_s      link_cfg
);
	// Rank drives arbitration, rate must match the master
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_cfg <= '0;
		end else if (cfg_valid) begin
			link_cfg <= cfg_in;
		end
	end
endmodule

// [cnsc_pkg.sv]
// Purpose: Shared constants and types for the CAN node strap decoder
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Register map offsets are byte addresses
package cnsc_pkg;

	localparam logic [3:0] CNSC_OFS_NODE   = 4'h0;
	localparam logic [3:0] CNSC_OFS_PROTO  = 4'h4;
	localparam logic [3:0] CNSC_OFS_CTRL   = 4'h8;
	localparam logic [3:0] CNSC_OFS_STATUS = 4'hC;

	localparam logic [1:0] CNSC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CNSC_RESP_SLVERR = 2'h2;

	localparam logic [4:0] CNSC_NODE_RST    = 5'h00;
	localparam logic [1:0] CNSC_RATE_RST    = 2'h0;
	localparam logic [4:0] CNSC_PRIO_TOP    = 5'h1F;
	localparam logic [2:0] CNSC_SETTLE_CYC  = 3'h3;

	typedef enum logic [1:0] {
		CNSC_RATE_1000K = 2'b11,
		CNSC_RATE_800K  = 2'b10,
		CNSC_RATE_500K  = 2'b01,
		CNSC_RATE_250K  = 2'b00
	} cnsc_rate_e;

	typedef enum logic [1:0] {
		CNSC_ST_SETTLE = 2'b00,
		CNSC_ST_LOAD   = 2'b01,
		CNSC_ST_HOLD   = 2'b10
	} cnsc_state_e;

	typedef struct packed {
		logic [3:0] rotary;
		logic       proto_open;
		logic       rate_a;
		logic       rate_b;
		logic       bank_hi;
	} cnsc_strap_s;

	typedef struct packed {
		logic [4:0] node_pos;
		logic [4:0] priority_rank;
		logic       proto_open;
		cnsc_rate_e bitrate_select;
	} cnsc_cfg_s;

	// Switch two off with three on is the 800 kHz setting, not a plain bit copy
	function automatic cnsc_rate_e cnsc_rate_decode(input logic sw2, input logic sw3);
		cnsc_rate_e r;
		case ({sw2, sw3})
			2'b11: begin
				r = CNSC_RATE_1000K;
			end
			2'b01: begin
				r = CNSC_RATE_800K;
			end
			2'b10: begin
				r = CNSC_RATE_500K;
			end
			default: begin
				r = CNSC_RATE_250K;
			end
		endcase
		return r;
	endfunction

endpackage

// [cnsc_strap_config.sv]
// Purpose: Capture node position, protocol and bit rate from panel switches at reset
// Assumes: Switch inputs are asynchronous; aresetn is synchronous active low
// Notes:   Overview list below; registers reachable over AXI4-Lite
//
// Overview of operation
// - The low four node-position bits come from the sixteen-position rotary switch.
// - The bank switch is the fifth position bit, giving 0-15 when off and 16-31 when on.
// - A new node position takes effect only after a module reset.
// - A lower node position gives a higher arbitration priority.
// - DIP switch one selects the proprietary variant when off and CANopen when on.
// - Switches two and three pick 1000, 800, 500 or 250 kHz in CANopen mode.
// - All CANopen nodes, master included, must run the same bit rate.
// - A changed bit rate takes effect only after a module reset.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cnsc_strap_config
	import cnsc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  rotary_sw,
	input  wire logic        bank_sw,
	input  wire logic        proto_sw,
	input  wire logic        rate_sw2,
	input  wire logic        rate_sw3,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output cnsc_cfg_s        cfg_out,
	output logic             cfg_valid
);

	cnsc_strap_s s1_ff, s2_ff, s3_ff;
	cnsc_strap_s raw;
	cnsc_state_e st_ff, nxt_st;
	logic [2:0]  cnt_ff, nxt_cnt;
	cnsc_cfg_s   cfg_ff, nxt_cfg;
	logic        vld_ff, nxt_vld;
	logic        rate_ok_ff, nxt_rate_ok;
	logic        awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;

	// Bus state
	logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
	logic [3:0]  awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
	logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;

	assign raw = '{rotary: rotary_sw, proto_open: proto_sw, rate_a: rate_sw2,
		rate_b: rate_sw3, bank_hi: bank_sw};

	// Three-stage synchroniser; only s2/s3 are compared
	always_ff @(posedge aclk) begin
		s1_ff <= raw;
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end

	// Straps must read stable for several cycles, so a bouncing switch at release is not caught
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		nxt_cfg = cfg_ff;
		nxt_vld = vld_ff;
		case (st_ff)
			CNSC_ST_SETTLE: begin
				if (s2_ff != s3_ff) begin
					nxt_cnt = 3'h0;
				end else if (cnt_ff == CNSC_SETTLE_CYC) begin
					nxt_st = CNSC_ST_LOAD;
				end else begin
					nxt_cnt = cnt_ff + 3'h1;
				end
			end
			CNSC_ST_LOAD: begin
				nxt_cfg.node_pos       = {s3_ff.bank_hi, s3_ff.rotary};
				nxt_cfg.priority_rank  = CNSC_PRIO_TOP - {s3_ff.bank_hi, s3_ff.rotary};
				nxt_cfg.proto_open     = s3_ff.proto_open;
				nxt_cfg.bitrate_select = cnsc_rate_decode(s3_ff.rate_a, s3_ff.rate_b);
				nxt_vld = 1'b1;
				nxt_st  = CNSC_ST_HOLD;
			end
			CNSC_ST_HOLD: begin
				nxt_st = CNSC_ST_HOLD;
			end
			default: begin
				nxt_st = CNSC_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff  <= CNSC_ST_SETTLE;
			cnt_ff <= 3'h0;
			cfg_ff <= '{node_pos: CNSC_NODE_RST, priority_rank: CNSC_PRIO_TOP,
				proto_open: 1'b0, bitrate_select: cnsc_rate_e'(CNSC_RATE_RST)};
			vld_ff <= 1'b0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
			cfg_ff <= nxt_cfg;
			vld_ff <= nxt_vld;
		end
	end

	assign cfg_out   = cfg_ff;
	assign cfg_valid = vld_ff;

	// Software may flag that the master confirmed a matching rate
	always_comb begin
		nxt_aw = aw_ff;
		nxt_awa = awa_ff;
		nxt_w = w_ff;
		nxt_wd = wd_ff;
		nxt_bv = bv_ff;
		nxt_br = br_ff;
		nxt_rv = rv_ff;
		nxt_rd = rd_ff;
		nxt_rr = rr_ff;
		nxt_rate_ok = rate_ok_ff;
		if (s_axi_awvalid && !aw_ff && !bv_ff) begin
			nxt_aw = 1'b1;
			nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_ff && !bv_ff) begin
			nxt_w = 1'b1;
			nxt_wd = s_axi_wdata;
		end
		if (aw_ff && w_ff) begin
			nxt_aw = 1'b0;
			nxt_w  = 1'b0;
			nxt_bv = 1'b1;
			nxt_br = CNSC_RESP_OKAY;
			case (awa_ff)
				CNSC_OFS_CTRL: begin
					nxt_rate_ok = wd_ff[0];
				end
				CNSC_OFS_NODE, CNSC_OFS_PROTO, CNSC_OFS_STATUS: begin
					nxt_br = CNSC_RESP_OKAY;
				end
				default: begin
					nxt_br = CNSC_RESP_SLVERR;
				end
			endcase
		end
		if (bv_ff && s_axi_bready) begin
			nxt_bv = 1'b0;
		end
		if (s_axi_arvalid && !rv_ff) begin
			nxt_rv = 1'b1;
			nxt_rr = CNSC_RESP_OKAY;
			case (s_axi_araddr)
				CNSC_OFS_NODE:   nxt_rd = {22'h0, cfg_ff.priority_rank, cfg_ff.node_pos};
				CNSC_OFS_PROTO:  nxt_rd = {29'h0, cfg_ff.bitrate_select, cfg_ff.proto_open};
				CNSC_OFS_CTRL:   nxt_rd = {31'h0, rate_ok_ff};
				CNSC_OFS_STATUS: nxt_rd = {30'h0, st_ff == CNSC_ST_SETTLE, vld_ff};
				default: begin
					nxt_rd = 32'h0;
					nxt_rr = CNSC_RESP_SLVERR;
				end
			endcase
		end else if (rv_ff && s_axi_rready) begin
			nxt_rv = 1'b0;
		end
		// Ready taken from next state so the port is a flop with unchanged timing
		nxt_awrdy = !nxt_aw && !nxt_bv;
		nxt_wrdy  = !nxt_w && !nxt_bv;
		nxt_arrdy = !nxt_rv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			awa_ff <= 4'h0;
			w_ff <= 1'b0;
			wd_ff <= 32'h0;
			bv_ff <= 1'b0;
			br_ff <= 2'h0;
			rv_ff <= 1'b0;
			rd_ff <= 32'h0;
			rr_ff <= 2'h0;
			rate_ok_ff <= 1'b0;
			awrdy_ff <= 1'b1;
			wrdy_ff <= 1'b1;
			arrdy_ff <= 1'b1;
		end else begin
			aw_ff <= nxt_aw;
			awa_ff <= nxt_awa;
			w_ff <= nxt_w;
			wd_ff <= nxt_wd;
			bv_ff <= nxt_bv;
			br_ff <= nxt_br;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
			rr_ff <= nxt_rr;
			rate_ok_ff <= nxt_rate_ok;
			awrdy_ff <= nxt_awrdy;
			wrdy_ff <= nxt_wrdy;
			arrdy_ff <= nxt_arrdy;
		end
	end

	assign s_axi_awready = awrdy_ff;
	assign s_axi_wready  = wrdy_ff;
	assign s_axi_bvalid  = bv_ff;
	assign s_axi_bresp   = br_ff;
	assign s_axi_arready = arrdy_ff;
	assign s_axi_rvalid  = rv_ff;
	assign s_axi_rdata   = rd_ff;
	assign s_axi_rresp   = rr_ff;

	a_node_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == CNSC_ST_LOAD |=> cfg_ff.node_pos[3:0] == $past(s3_ff.rotary))
		else $error("node low bits differ from rotary");
	a_bank_bit: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == CNSC_ST_LOAD |=> cfg_ff.node_pos[4] == $past(s3_ff.bank_hi))
		else $error("bank bit not in node position");
	a_hold_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
		vld_ff |=> vld_ff && $stable(cfg_ff))
		else $error("config changed without reset");
	a_prio_order: assert property (@(posedge aclk) disable iff (!aresetn)
		vld_ff |-> cfg_ff.priority_rank + cfg_ff.node_pos == CNSC_PRIO_TOP)
		else $error("priority not inverse of position");
	a_proto_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == CNSC_ST_LOAD |=> cfg_ff.proto_open == $past(s3_ff.proto_open))
		else $error("protocol select mismatch");
	a_rate_map: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == CNSC_ST_LOAD |=> cfg_ff.bitrate_select == ($past(s3_ff.rate_a) ?
		($past(s3_ff.rate_b) ? CNSC_RATE_1000K : CNSC_RATE_500K) :
		($past(s3_ff.rate_b) ? CNSC_RATE_800K : CNSC_RATE_250K)))
		else $error("bit rate decode mismatch");
	a_rate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		vld_ff ##1 vld_ff |-> $stable(cfg_ff.bitrate_select))
		else $error("bit rate moved after load");
	a_load_once: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(vld_ff) |-> $past(st_ff) == CNSC_ST_LOAD ##1 st_ff == CNSC_ST_HOLD [*3])
		else $error("load not single or hold left");
	a_rate_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_ff && w_ff && awa_ff == CNSC_OFS_CTRL |=> rate_ok_ff == $past(wd_ff[0]))
		else $error("rate confirm flag not written");

endmodule

// [tb_can_node_strap_config.sv]
// Purpose: Self-checking bench for the strap capture and its register view
// Assumes: Master rate matches the strap rate; node zero left to the master
// Notes:   Expected values queued by the driver, popped by the monitor
`timescale 1ns/1ns
module tb_can_node_strap_config
	import cnsc_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, bank_sw = 1'b0, proto_sw = 1'b0;
	logic        rate_sw2 = 1'b0, rate_sw3 = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, cfg_valid, cv_q = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  rotary_sw = 4'h0, awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'h2C;
	logic [1:0]  bresp, rresp;
	cnsc_cfg_s   cfg_out, link_cfg, e;
	logic [33:0] rq[$], rx;
	logic [31:0] cq[$];
	logic [1:0]  bq[$];
	int          err_total = 0, n_compared = 0, k;

	always #2 aclk = ~aclk;

	cnsc_strap_config u_dut (.aclk(aclk), .aresetn(aresetn), .rotary_sw(rotary_sw),
		.bank_sw(bank_sw), .proto_sw(proto_sw), .rate_sw2(rate_sw2), .rate_sw3(rate_sw3),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cfg_out(cfg_out), .cfg_valid(cfg_valid));
	cnsc_can_model u_can (.aclk(aclk), .aresetn(aresetn), .cfg_in(cfg_out),
		.cfg_valid(cfg_valid), .link_cfg(link_cfg));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Trailing edge keeps a following call from re-raising rready in the same step
	task automatic rd(input logic [3:0] a, input logic [31:0] x,
		input logic [1:0] r = CNSC_RESP_OKAY);
		rq.push_back({r, x});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r = CNSC_RESP_OKAY);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Straps are set under reset, then moved once captured
	task automatic run(input int i, input logic p);
		logic [4:0] n;
		logic [1:0] sw;
		n = (i == 0) ? 5'h1F : 5'(xs());
		if (n == 5'h00) n = 5'h01;
		sw = p ? i[1:0] : 2'h0;
		e.node_pos = n;
		e.priority_rank = CNSC_PRIO_TOP - n;
		e.proto_open = p;
		e.bitrate_select = sw[1] ? (sw[0] ? CNSC_RATE_1000K : CNSC_RATE_500K) :
			(sw[0] ? CNSC_RATE_800K : CNSC_RATE_250K);
		cq.push_back(32'(e));
		{bank_sw, rotary_sw} <= n;
		proto_sw <= p;
		{rate_sw2, rate_sw3} <= sw;
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CNSC_OFS_STATUS, 32'h2);
		for (k = 0; k < 50 && cfg_valid !== 1'b1; k++) @(posedge aclk);
		@(posedge aclk);
		{bank_sw, rotary_sw, proto_sw, rate_sw2, rate_sw3} <= ~{n, p, sw};
		repeat (10) @(posedge aclk);
		rd(CNSC_OFS_NODE, {22'h0, e.priority_rank, n});
		rd(CNSC_OFS_PROTO, {29'h0, e.bitrate_select, p});
		rd(CNSC_OFS_STATUS, 32'h1);
		chk(32'(link_cfg), 32'(e));
		$display("Strap test %0d done", i);
	endtask

	always @(posedge aclk) begin
		cv_q <= cfg_valid;
		if (rvalid === 1'b1 && rready === 1'b1) begin
			rx = rq.pop_front();
			chk(rdata, rx[31:0]);
			chk(32'(rresp), 32'(rx[33:32]));
		end
		if (bvalid === 1'b1 && bready === 1'b1) chk(32'(bresp), 32'(bq.pop_front()));
		if (cfg_valid === 1'b1 && cv_q !== 1'b1) chk(32'(cfg_out), cq.pop_front());
	end

	initial begin
		for (int i = 0; i < 4; i++) run(i, 1'b1);
		run(1, 1'b0);
		wr(CNSC_OFS_CTRL, 32'h1);
		rd(CNSC_OFS_CTRL, 32'h1);
		wr(CNSC_OFS_NODE, 32'hFFFF);
		rd(CNSC_OFS_NODE, {22'h0, e.priority_rank, e.node_pos});
		rd(4'h2, 32'h0, CNSC_RESP_SLVERR);
		wr(4'h2, 32'h0, CNSC_RESP_SLVERR);
		rd(CNSC_OFS_CTRL, 32'h1);
		$display("Register test done");
		close_out();
	end

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		close_out();
	end
endmodule
